/* logic/mps_pkg.sv */
// package for the module power sequencer: modes, timings, command values
// assumes one 50 MHz clock shared by the module end and the host end
//
// Overview of operation
// - key low 500 ms from off powers up
// - host releases key after status goes high
// - host waits 60 ms supply stable first
// - key low 800 ms, shutdown after release
// - power-off command shuts down like key
// - host keeps key high after power-off command
// - restart pulse 250 to 600 ms resets module
// - restart only as fallback after failed shutdown
// - host cuts supply only after shutdown completes
// - auto power-on level high powers module on
// - radio kill low or mode 4: airplane
// - airplane mode rejects radio commands
// - mode 0 disables radio and SIM
// - sleep needs sleep allow and USB suspend
// - wake on USB data; report wakes host
// - no-suspend host: sleep when VBUS removed
// - sleep still accepts paging, SMS, data
// - power-down: all interfaces unreachable
// - key may be tied low for always-on
// - undriven key and restart read inactive high
package mps_pkg;

    // clock rate in kHz, so that ms times convert cleanly
    localparam int unsigned CLK_KHZ        = 50_000;

    // documented times in milliseconds
    localparam int unsigned T_ON_MS        = 500;
    localparam int unsigned T_OFF_MS       = 800;
    localparam int unsigned T_SUPPLY_MS    = 60;
    localparam int unsigned T_RST_MIN_MS   = 250;
    localparam int unsigned T_RST_MAX_MS   = 600;
    // host-chosen times within the documented windows
    localparam int unsigned T_RST_USE_MS   = 400;
    localparam int unsigned T_STEP_MS      = 10;

    // cycle counts derived from the times
    localparam int unsigned CYC_ON      = T_ON_MS * CLK_KHZ;
    localparam int unsigned CYC_OFF     = T_OFF_MS * CLK_KHZ;
    localparam int unsigned CYC_SUPPLY  = T_SUPPLY_MS * CLK_KHZ;
    localparam int unsigned CYC_RST_MIN = T_RST_MIN_MS * CLK_KHZ;
    localparam int unsigned CYC_RST_MAX = T_RST_MAX_MS * CLK_KHZ;
    localparam int unsigned CYC_RST_USE = T_RST_USE_MS * CLK_KHZ;
    localparam int unsigned CYC_STEP    = T_STEP_MS * CLK_KHZ;

    // counter width large enough for the longest figure
    localparam int unsigned CNT_W       = 26;

    // functionality command values
    localparam logic [2:0] FUN_MIN      = 3'h0;
    localparam logic [2:0] FUN_FULL     = 3'h1;
    localparam logic [2:0] FUN_AIRPLANE = 3'h4;

    // operating mode reported by the module
    typedef enum logic [5:0] {
        MPS_OFF      = 6'b00_0001,
        MPS_BOOT     = 6'b00_0010,
        MPS_ON       = 6'b00_0100,
        MPS_SLEEP    = 6'b00_1000,
        MPS_SHUT     = 6'b01_0000,
        MPS_RESET    = 6'b10_0000
    } mps_mode_e;

endpackage

/* logic/mps_if.sv */
// interface joining the module end and the host end of the control pins
// assumes both ends run on clk_sys; open-drain pins resolved here
`timescale 1ns/1ps
interface mps_if;
    // open-drain key and restart: enables pull low, pull-up when released
    logic power_key_oe;      // host pulls key low
    logic hard_restart_oe;   // host pulls restart low
    logic power_key_n;       // resolved key level
    logic hard_restart_low;  // resolved restart level
    // plain levels driven by the host
    logic auto_power_on_level;
    logic radio_kill_low;
    logic usb_suspend;       // host usb port in suspend
    logic usb_vbus;          // usb bus power present
    logic usb_host_data;     // host sends usb data (pulse)
    // driven by the module
    logic status;            // module operating indication
    logic remote_wakeup;     // remote wakeup signalling (pulse)

    // internal pull-ups make an undriven pin read high
    assign power_key_n      = ~power_key_oe;
    assign hard_restart_low = ~hard_restart_oe;

    modport module_end (
        input  power_key_n, hard_restart_low, auto_power_on_level,
        input  radio_kill_low, usb_suspend, usb_vbus, usb_host_data,
        output status, remote_wakeup
    );
    modport host_end (
        output power_key_oe, hard_restart_oe, auto_power_on_level,
        output radio_kill_low, usb_suspend, usb_vbus, usb_host_data,
        input  status, remote_wakeup
    );
endinterface

/* logic/mps_module.sv */
// module end: power, reset, functionality and sleep sequencing
// assumes pin levels are synchronous to clk_sys and host keeps its rules
`timescale 1ns/1ps
module mps_module #(
    parameter int unsigned ON_CYC  = mps_pkg::CYC_ON,
    parameter int unsigned OFF_CYC = mps_pkg::CYC_OFF,
    parameter int unsigned RST_CYC = mps_pkg::CYC_RST_MIN,
    parameter int unsigned BOOT_CYC = 16,
    parameter int unsigned SHUT_CYC = 16
) (
    // clock and reset
    input  wire logic            clk_sys,
    input  wire logic            rst,
    // link to the host
    mps_if.module_end            lnk,
    // software commands from the module firmware side
    input  wire logic            cmd_power_off,
    input  wire logic            cmd_fun_valid,
    input  wire logic [2:0]      cmd_fun_value,
    input  wire logic            cmd_sleep_allow_valid,
    input  wire logic            cmd_sleep_allow,
    input  wire logic            cmd_radio_req,
    input  wire logic            urc_pending,
    input  wire logic            remote_wakeup_host,
    // state reported to the firmware side
    output logic [5:0]           mode,
    output logic                 radio_on,
    output logic                 sim_on,
    output logic                 radio_cmd_reject,
    output logic                 iface_on,
    output logic                 net_rx_on
);
    localparam int unsigned CW = mps_pkg::CNT_W;

    initial begin
        if (ON_CYC < 1 || OFF_CYC <= ON_CYC || RST_CYC < 1 ||
            BOOT_CYC < 1 || SHUT_CYC < 1 || OFF_CYC >= (1 << CW))
            $error("mps_module: bad timing parameters");
    end

    // main sequencer state
    mps_pkg::mps_mode_e    st_r, st_nxt;
    logic [CW-1:0]         key_cnt_r, key_cnt_nxt;   // key low time
    logic [CW-1:0]         rst_cnt_r, rst_cnt_nxt;   // restart low time
    logic [CW-1:0]         tmr_r, tmr_nxt;           // boot/shut timer
    logic                  off_armed_r, off_armed_nxt; // key held 800 ms
    logic                  key_rel_r, key_rel_nxt;   // key seen high since on
    logic [2:0]            fun_r, fun_nxt;           // functionality value
    logic                  sclk_r, sclk_nxt;         // sleep allowed
    logic                  status_r, status_nxt;
    logic                  wake_r, wake_nxt;
    logic [5:0]            mode_r;
    logic                  radio_r, sim_r, rej_r, ifc_r, rx_r;
    logic                  airplane;
    logic                  sleep_ok;

    // saturating increment shared by both pin timers
    function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v,
                                              input logic low);
        if (!low)
            sat_inc = '0;
        else if (&v)
            sat_inc = v;
        else
            sat_inc = v + 1'b1;
    endfunction

    // airplane from pin or value 4
    assign airplane = !lnk.radio_kill_low ||
                      fun_r == mps_pkg::FUN_AIRPLANE;
    // sleep: allowed and usb suspended or bus power gone
    assign sleep_ok = sclk_r && (lnk.usb_suspend || !lnk.usb_vbus);

    // next-state logic of the sequencer
    always_comb begin
        st_nxt        = st_r;
        tmr_nxt       = tmr_r;
        fun_nxt       = fun_r;
        sclk_nxt      = sclk_r;
        off_armed_nxt = off_armed_r;
        key_rel_nxt   = key_rel_r;
        wake_nxt      = 1'b0;
        // key and restart read low only when pulled down
        key_cnt_nxt   = sat_inc(key_cnt_r, !lnk.power_key_n);
        rst_cnt_nxt   = sat_inc(rst_cnt_r, !lnk.hard_restart_low);
        // firmware commands update only while software runs
        if (st_r == mps_pkg::MPS_ON || st_r == mps_pkg::MPS_SLEEP) begin
            if (cmd_fun_valid)
                fun_nxt = cmd_fun_value;
            if (cmd_sleep_allow_valid)
                sclk_nxt = cmd_sleep_allow;
        end
        case (st_r)
            mps_pkg::MPS_OFF: begin
                // key held 500 ms or auto level high powers up
                if (key_cnt_r >= CW'(ON_CYC - 1) ||
                    lnk.auto_power_on_level) begin
                    st_nxt      = mps_pkg::MPS_BOOT;
                    tmr_nxt     = '0;
                    key_rel_nxt = 1'b0;
                end
            end
            mps_pkg::MPS_BOOT: begin
                tmr_nxt = tmr_r + 1'b1;
                if (tmr_r >= CW'(BOOT_CYC - 1)) begin
                    st_nxt  = mps_pkg::MPS_ON;
                    fun_nxt = mps_pkg::FUN_FULL;
                    sclk_nxt = 1'b0;
                end
            end
            mps_pkg::MPS_ON, mps_pkg::MPS_SLEEP: begin
                // the power-up press must end before an off press counts
                if (lnk.power_key_n)
                    key_rel_nxt = 1'b1;
                if (key_rel_r && key_cnt_r >= CW'(OFF_CYC - 1))
                    off_armed_nxt = 1'b1;
                if (st_r == mps_pkg::MPS_SLEEP) begin
                    // host data or returning bus power wakes
                    if (lnk.usb_host_data || !sleep_ok)
                        st_nxt = mps_pkg::MPS_ON;
                    // pending report raises remote wakeup
                    else if (urc_pending && remote_wakeup_host)
                        wake_nxt = 1'b1;
                end else if (sleep_ok && !lnk.usb_host_data)
                    st_nxt = mps_pkg::MPS_SLEEP;
                // shutdown after key release, or by command
                if ((off_armed_r && lnk.power_key_n) || cmd_power_off) begin
                    st_nxt        = mps_pkg::MPS_SHUT;
                    tmr_nxt       = '0;
                    off_armed_nxt = 1'b0;
                end
            end
            mps_pkg::MPS_SHUT: begin
                tmr_nxt = tmr_r + 1'b1;
                if (tmr_r >= CW'(SHUT_CYC - 1))
                    st_nxt = mps_pkg::MPS_OFF;
            end
            mps_pkg::MPS_RESET: begin
                // module restarts once the pulse is released
                if (lnk.hard_restart_low) begin
                    st_nxt      = mps_pkg::MPS_BOOT;
                    tmr_nxt     = '0;
                    key_rel_nxt = 1'b0;
                end
            end
            default: st_nxt = mps_pkg::MPS_OFF;
        endcase
        // a long enough restart pulse overrides any running mode
        if (st_r != mps_pkg::MPS_OFF && st_r != mps_pkg::MPS_RESET &&
            rst_cnt_r >= CW'(RST_CYC - 1)) begin
            st_nxt        = mps_pkg::MPS_RESET;
            off_armed_nxt = 1'b0;
            wake_nxt      = 1'b0;
        end
        status_nxt = st_nxt == mps_pkg::MPS_ON ||
                     st_nxt == mps_pkg::MPS_SLEEP;
    end

    // sequencer registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r        <= mps_pkg::MPS_OFF;
            key_cnt_r   <= '0;
            rst_cnt_r   <= '0;
            tmr_r       <= '0;
            off_armed_r <= 1'b0;
            key_rel_r   <= 1'b0;
            fun_r       <= mps_pkg::FUN_FULL;
            sclk_r      <= 1'b0;
            status_r    <= 1'b0;
            wake_r      <= 1'b0;
        end else begin
            st_r        <= st_nxt;
            key_cnt_r   <= key_cnt_nxt;
            rst_cnt_r   <= rst_cnt_nxt;
            tmr_r       <= tmr_nxt;
            off_armed_r <= off_armed_nxt;
            key_rel_r   <= key_rel_nxt;
            fun_r       <= fun_nxt;
            sclk_r      <= sclk_nxt;
            status_r    <= status_nxt;
            wake_r      <= wake_nxt;
        end
    end

    // registered mode outputs, decoded from current state
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mode_r  <= mps_pkg::MPS_OFF;
            radio_r <= 1'b0;
            sim_r   <= 1'b0;
            rej_r   <= 1'b0;
            ifc_r   <= 1'b0;
            rx_r    <= 1'b0;
        end else begin
            mode_r  <= st_r;
            // interfaces only while software runs
            ifc_r   <= st_r == mps_pkg::MPS_ON ||
                       st_r == mps_pkg::MPS_SLEEP;
            // radio off in airplane or minimum mode
            radio_r <= (st_r == mps_pkg::MPS_ON ||
                        st_r == mps_pkg::MPS_SLEEP) && !airplane &&
                       fun_r != mps_pkg::FUN_MIN;
            sim_r   <= (st_r == mps_pkg::MPS_ON ||
                        st_r == mps_pkg::MPS_SLEEP) &&
                       fun_r != mps_pkg::FUN_MIN;
            // radio commands refused in airplane or minimum mode, or in any state but on
            rej_r   <= cmd_radio_req && (airplane ||
                       fun_r == mps_pkg::FUN_MIN ||
                       st_r != mps_pkg::MPS_ON);
            // paging, sms and data still received in sleep
            rx_r    <= (st_r == mps_pkg::MPS_ON ||
                        st_r == mps_pkg::MPS_SLEEP) && !airplane &&
                       fun_r != mps_pkg::FUN_MIN;
        end
    end

    assign lnk.status        = status_r;
    assign lnk.remote_wakeup = wake_r;
    assign mode              = mode_r;
    assign radio_on          = radio_r;
    assign sim_on            = sim_r;
    assign radio_cmd_reject  = rej_r;
    assign iface_on          = ifc_r;
    assign net_rx_on         = rx_r;
endmodule

/* logic/mps_host.sv */
// host end: drives key, restart, radio kill and usb levels on request
// assumes supply_good comes from the board supply monitor
`timescale 1ns/1ps
module mps_host #(
    parameter int unsigned ON_CYC     = mps_pkg::CYC_ON,
    parameter int unsigned OFF_CYC    = mps_pkg::CYC_OFF,
    parameter int unsigned SUPPLY_CYC = mps_pkg::CYC_SUPPLY,
    parameter int unsigned RST_CYC    = mps_pkg::CYC_RST_USE
) (
    // clock and reset
    input  wire logic            clk_sys,
    input  wire logic            rst,
    // link to the module
    mps_if.host_end              lnk,
    // user requests (pulses) and levels
    input  wire logic            supply_good,
    input  wire logic            req_on,
    input  wire logic            req_off,
    input  wire logic            req_restart,
    input  wire logic            auto_on,
    input  wire logic            radio_kill,
    input  wire logic            usb_suspend_req,
    input  wire logic            vbus_on,
    input  wire logic            usb_data,
    // user status
    output logic                 busy,
    output logic                 module_up,
    output logic                 host_wake
);
    localparam int unsigned CW = mps_pkg::CNT_W;

    initial begin
        if (ON_CYC < 1 || OFF_CYC < 1 || RST_CYC < mps_pkg::CYC_RST_MIN ||
            RST_CYC > mps_pkg::CYC_RST_MAX || OFF_CYC >= (1 << CW))
            $error("mps_host: bad timing parameters");
    end

    typedef enum logic [3:0] {
        MPH_IDLE = 4'b0001,
        MPH_ON   = 4'b0010,
        MPH_OFF  = 4'b0100,
        MPH_RST  = 4'b1000
    } mph_state_e;

    mph_state_e       st_r, st_nxt;
    logic [CW-1:0]    cnt_r, cnt_nxt;     // pulse length counter
    logic [CW-1:0]    sup_r, sup_nxt;     // supply stable time
    logic             key_r, key_nxt, rs_r, rs_nxt;
    logic             sup_ok;

    // supply must be stable 60 ms before a key press
    assign sup_ok = sup_r >= CW'(SUPPLY_CYC);

    // one pulse at a time, never key and restart together
    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r + 1'b1;
        key_nxt = 1'b0;
        rs_nxt  = 1'b0;
        sup_nxt = !supply_good ? '0 : (sup_ok ? sup_r : sup_r + 1'b1);
        case (st_r)
            MPH_IDLE: begin
                cnt_nxt = '0;
                if (req_restart) begin     // fallback use is the user's
                    st_nxt = MPH_RST;
                    rs_nxt = 1'b1;
                end else if (req_on && sup_ok && !lnk.status) begin
                    st_nxt  = MPH_ON;
                    key_nxt = 1'b1;
                end else if (req_off && lnk.status) begin
                    st_nxt  = MPH_OFF;
                    key_nxt = 1'b1;
                end
            end
            MPH_ON: begin
                // hold 500 ms and until status is high
                key_nxt = 1'b1;
                if (cnt_r >= CW'(ON_CYC) && lnk.status) begin
                    st_nxt  = MPH_IDLE;
                    key_nxt = 1'b0;
                end
            end
            MPH_OFF: begin
                key_nxt = 1'b1;            // at least 800 ms
                if (cnt_r >= CW'(OFF_CYC)) begin
                    st_nxt  = MPH_IDLE;
                    key_nxt = 1'b0;
                end
            end
            MPH_RST: begin
                rs_nxt = 1'b1;             // pulse inside 250..600 ms
                if (cnt_r >= CW'(RST_CYC - 1)) begin
                    st_nxt = MPH_IDLE;
                    rs_nxt = 1'b0;
                end
            end
            default: st_nxt = MPH_IDLE;
        endcase
    end

    // host registers; key released high when idle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r  <= MPH_IDLE;
            cnt_r <= '0;
            sup_r <= '0;
            key_r <= 1'b0;
            rs_r  <= 1'b0;
            lnk.auto_power_on_level <= 1'b0;
            lnk.radio_kill_low      <= 1'b1;
            lnk.usb_suspend         <= 1'b0;
            lnk.usb_vbus            <= 1'b1;
            lnk.usb_host_data       <= 1'b0;
            busy      <= 1'b0;
            module_up <= 1'b0;
            host_wake <= 1'b0;
        end else begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
            sup_r <= sup_nxt;
            key_r <= key_nxt;
            rs_r  <= rs_nxt;
            lnk.auto_power_on_level <= auto_on;   // tie low if unused
            lnk.radio_kill_low      <= !radio_kill;
            lnk.usb_suspend         <= usb_suspend_req;
            lnk.usb_vbus            <= vbus_on;
            lnk.usb_host_data       <= usb_data;
            busy      <= st_nxt != MPH_IDLE;
            module_up <= lnk.status;
            host_wake <= lnk.remote_wakeup;
        end
    end

    assign lnk.power_key_oe    = key_r;
    assign lnk.hard_restart_oe = rs_r;
endmodule

/* test/mps_assertions.sv */
// checker for the control pins between the host end and the module end
// assumes it watches the one link that joins both design ends on clk_sys
`timescale 1ns/1ps
module mps_assertions #(
    parameter int unsigned ON_CYC  = 20,  // key low cycles to power up
    parameter int unsigned OFF_CYC = 40   // key low cycles to power down
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // pins driven by the host end
    input wire logic power_key_oe,
    input wire logic hard_restart_oe,
    input wire logic power_key_n,
    input wire logic hard_restart_low,
    input wire logic auto_power_on_level,
    input wire logic radio_kill_low,
    input wire logic usb_suspend,
    input wire logic usb_vbus,
    input wire logic usb_host_data,
    // pins driven by the module end
    input wire logic status,
    input wire logic remote_wakeup
);
    int unsigned low_cnt_r;    // consecutive cycles with the key low
    int unsigned low_cnt_nxt;  // next value of the run length

    // run length of a low key; saturates so a tied key never wraps
    always_comb begin
        low_cnt_nxt = 0;
        if (!power_key_n) begin
            low_cnt_nxt = (low_cnt_r < 1000) ? low_cnt_r + 1 : low_cnt_r;
        end
    end

    // register the run length
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            low_cnt_r <= 0;
        end else begin
            low_cnt_r <= low_cnt_nxt;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    key_pullup_a: assert property (
        power_key_n == !power_key_oe) else $error("key level is wrong");
    restart_pullup_a: assert property (
        hard_restart_low == !hard_restart_oe) else $error("restart level bad");
    no_overlap_a: assert property (
        !(power_key_oe && hard_restart_oe)) else $error("key and restart both");
    early_release_a: assert property (
        $fell(power_key_oe) |-> $past(status)) else $error("key freed early");
    on_press_a: assert property (
        $rose(status) && !auto_power_on_level |-> low_cnt_r >= ON_CYC)
        else $error("module up after a short press");
    off_release_a: assert property (
        $fell(status) |-> power_key_n) else $error("shutdown with key low");
    off_press_a: assert property (
        $rose(power_key_n) && status && low_cnt_r >= OFF_CYC |-> ##[0:3] !status)
        else $error("no shutdown after long press");
    auto_on_a: assert property (
        $rose(auto_power_on_level) && !status |-> ##[1:60] status)
        else $error("auto level did not power up");
    wake_sig_a: assert property (
        remote_wakeup |-> status) else $error("wakeup while powered down");
endmodule

/* test/tb.sv */
// self-checking bench: host end and module end joined by one link
// assumes shortened counts; the host restart pulse is long, so unused
`timescale 1ns/1ps
module tb;
    // clock and reset
    logic       clk_sys = 1'b0;
    logic       rst     = 1'b1;
    // module firmware side
    logic       cmd_power_off = 1'b0, cmd_fun_valid = 1'b0;
    logic [2:0] cmd_fun_value = 3'h1;
    logic       cmd_sleep_allow_valid = 1'b0, cmd_sleep_allow = 1'b0;
    logic       cmd_radio_req = 1'b0, urc_pending = 1'b0;
    logic       remote_wakeup_host = 1'b1, req_restart = 1'b0;
    logic [5:0] mode;
    logic       radio_on, sim_on, radio_cmd_reject, iface_on, net_rx_on;
    // host user side
    logic       supply_good = 1'b1, req_on = 1'b0, req_off = 1'b0;
    logic       auto_on = 1'b0, radio_kill = 1'b0, usb_suspend_req = 1'b0;
    logic       vbus_on = 1'b1, usb_data = 1'b0;
    logic       busy, module_up, host_wake;
    // bookkeeping
    int         error_cnt = 0;
    int         checks    = 0;

    mps_if lnk ();

    // a restart pulse needs 20 M cycles, so the request stays held low
    mps_host #(.ON_CYC(20), .OFF_CYC(40), .SUPPLY_CYC(5)) mps_host_inst (
        .clk_sys(clk_sys), .rst(rst), .lnk(lnk), .supply_good(supply_good),
        .req_on(req_on), .req_off(req_off), .req_restart(req_restart),
        .auto_on(auto_on), .radio_kill(radio_kill),
        .usb_suspend_req(usb_suspend_req), .vbus_on(vbus_on),
        .usb_data(usb_data), .busy(busy), .module_up(module_up),
        .host_wake(host_wake));

    mps_module #(.ON_CYC(20), .OFF_CYC(40)) mps_module_inst (
        .clk_sys(clk_sys), .rst(rst), .lnk(lnk),
        .cmd_power_off(cmd_power_off), .cmd_fun_valid(cmd_fun_valid),
        .cmd_fun_value(cmd_fun_value),
        .cmd_sleep_allow_valid(cmd_sleep_allow_valid),
        .cmd_sleep_allow(cmd_sleep_allow), .cmd_radio_req(cmd_radio_req),
        .urc_pending(urc_pending), .remote_wakeup_host(remote_wakeup_host),
        .mode(mode), .radio_on(radio_on), .sim_on(sim_on),
        .radio_cmd_reject(radio_cmd_reject), .iface_on(iface_on),
        .net_rx_on(net_rx_on));

    mps_assertions mps_assertions_inst (
        .clk_sys(clk_sys), .rst(rst), .power_key_oe(lnk.power_key_oe),
        .hard_restart_oe(lnk.hard_restart_oe), .power_key_n(lnk.power_key_n),
        .hard_restart_low(lnk.hard_restart_low),
        .auto_power_on_level(lnk.auto_power_on_level),
        .radio_kill_low(lnk.radio_kill_low), .usb_suspend(lnk.usb_suspend),
        .usb_vbus(lnk.usb_vbus), .usb_host_data(lnk.usb_host_data),
        .status(lnk.status), .remote_wakeup(lnk.remote_wakeup));

    // 50 MHz system clock
    always #10 clk_sys = ~clk_sys;

    // compare a mode word
    task automatic chk_mode(input logic [5:0] got, input logic [5:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t mode %h want %h", $time, got, exp);
        end
    endtask

    // compare a single level
    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t level %b want %b", $time, got, exp);
        end
    endtask

    // bounded wait for a mode; the compare afterwards reports a miss
    task automatic wait_mode(input logic [5:0] m);
        for (int i = 0; i < 400; i++) begin
            @(posedge clk_sys);
            #1;
            if (mode === m) break;
        end
    endtask

    // functionality command, then a few cycles for the levels to settle
    task automatic set_fun(input logic [2:0] v);
        @(posedge clk_sys);
        cmd_fun_value <= v;
        cmd_fun_valid <= 1'b1;
        @(posedge clk_sys);
        cmd_fun_valid <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    // radio command; the refusal pulse shows one cycle later
    task automatic radio_try();
        @(posedge clk_sys);
        cmd_radio_req <= 1'b1;
        @(posedge clk_sys);
        cmd_radio_req <= 0;
        #1;
    endtask

    // verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs a few hundred cycles
    initial begin
        #(20 * 20000);
        error_cnt++;
        $display("BAD %0t watchdog ran out", $time);
        stop_test();
    end

    // main sequence
    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        chk_mode(mode, mps_pkg::MPS_OFF);
        chk_bit(iface_on, 1'b0);
        repeat (10) @(posedge clk_sys);
        req_on <= 1'b1;
        @(posedge clk_sys);
        req_on <= 1'b0;
        wait_mode(mps_pkg::MPS_ON);
        chk_mode(mode, mps_pkg::MPS_ON);
        chk_bit(iface_on, 1'b1);
        repeat (4) @(posedge clk_sys);
        #1;
        chk_bit(lnk.power_key_n, 1'b1);
        $display("test power_on done");
        set_fun(mps_pkg::FUN_AIRPLANE);
        chk_bit(radio_on, 1'b0);
        chk_bit(sim_on, 1'b1);
        radio_try();
        chk_bit(radio_cmd_reject, 1'b1);
        set_fun(mps_pkg::FUN_MIN);
        chk_bit(radio_on, 1'b0);
        chk_bit(sim_on, 1'b0);
        set_fun(mps_pkg::FUN_FULL);
        chk_bit(radio_on, 1'b1);
        radio_try();
        chk_bit(radio_cmd_reject, 1'b0);
        radio_kill <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        chk_bit(radio_on, 1'b0);
        radio_try();
        chk_bit(radio_cmd_reject, 1'b1);
        radio_kill <= 1'b0;
        $display("test modes done");
        usb_suspend_req <= 1'b1;
        repeat (20) @(posedge clk_sys);
        #1;
        chk_mode(mode, mps_pkg::MPS_ON);
        @(posedge clk_sys);
        cmd_sleep_allow <= 1'b1;
        cmd_sleep_allow_valid <= 1'b1;
        @(posedge clk_sys);
        cmd_sleep_allow_valid <= 1'b0;
        wait_mode(mps_pkg::MPS_SLEEP);
        chk_mode(mode, mps_pkg::MPS_SLEEP);
        chk_bit(net_rx_on, 1'b1);
        @(posedge clk_sys);
        urc_pending <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(posedge clk_sys);
            #1;
            if (lnk.remote_wakeup === 1'b1) break;
        end
        chk_bit(lnk.remote_wakeup, 1'b1);
        @(posedge clk_sys);
        urc_pending <= 1'b0;
        usb_data <= 1'b1;
        wait_mode(mps_pkg::MPS_ON);
        chk_mode(mode, mps_pkg::MPS_ON);
        @(posedge clk_sys);
        usb_data <= 1'b0;
        usb_suspend_req <= 1'b0;
        vbus_on <= 1'b0;
        wait_mode(mps_pkg::MPS_SLEEP);
        chk_mode(mode, mps_pkg::MPS_SLEEP);
        @(posedge clk_sys);
        vbus_on <= 1'b1;
        wait_mode(mps_pkg::MPS_ON);
        chk_mode(mode, mps_pkg::MPS_ON);
        $display("test sleep done");
        @(posedge clk_sys);
        req_off <= 1'b1;
        @(posedge clk_sys);
        req_off <= 1'b0;
        wait_mode(mps_pkg::MPS_OFF);
        chk_mode(mode, mps_pkg::MPS_OFF);
        chk_bit(iface_on, 1'b0);
        $display("test key_off done");
        auto_on <= 1'b1;
        wait_mode(mps_pkg::MPS_ON);
        chk_mode(mode, mps_pkg::MPS_ON);
        @(posedge clk_sys);
        auto_on <= 1'b0;
        cmd_power_off <= 1'b1;
        @(posedge clk_sys);
        cmd_power_off <= 1'b0;
        wait_mode(mps_pkg::MPS_OFF);
        chk_mode(mode, mps_pkg::MPS_OFF);
        repeat (50) @(posedge clk_sys);
        #1;
        chk_bit(lnk.power_key_n, 1'b1);
        chk_mode(mode, mps_pkg::MPS_OFF);
        $display("test command_off done");
        stop_test();
    end
endmodule
